// >>> rtl/sfs_consts.svh
// opcodes, status field positions, reset values and counts for the
// serial status front end; included by the front-end design file only.
//
// Operation
// R01: chip select high: standby, output floated, inputs ignored
// R02: host lowers chip select before any op-code
// R03: hold low suspends transfer and floats output
// R04: sample input on rising, change output falling
// R05: host sends op-code, address, data on input
// R06: array and status data leave on output
// R07: modes 0 and 3, either idle level
// R08: slave only, one select per device
// R09: status writes gated by protect pin, enable bit
// R10: bit 7 is the protect enable bit
// R11: bits 6 to 4 are spare storage
// R12: bits 3 and 2 are block protect
// R13: bit 1 latch: set, clear, read only
// R14: latch clears at power-on and clear command
// R15: latch stays set after status/number/sector writes
// R16: bit 0 always reads zero
// R17: partial op-code at select rise is discarded
// R18: op-codes 06, 04, 05 and 01 decoded
// R19: status byte repeats while clocks continue
// R20: status write ignores input bits 1, 0
// R21: all bytes shifted most significant bit first
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

`define SFS_OP_SET_LATCH   8'h06
`define SFS_OP_CLEAR_LATCH 8'h04
`define SFS_OP_STATUS_RD   8'h05
`define SFS_OP_STATUS_WR   8'h01
`define SFS_OP_SERIAL_WR   8'hC2
`define SFS_OP_SECTOR_WR   8'h42

`define SFS_BIT_PROTECT_EN 7
`define SFS_NV_HI          7
`define SFS_NV_LO          2
`define SFS_BIT_LATCH      1
`define SFS_BIT_ZERO       0

`define SFS_NV_RESET       6'h00
`define SFS_LATCH_RESET    1'b0
`define SFS_LAST_BIT       3'h7

`endif

// >>> rtl/sfs_front_end.sv
// serial slave front end with the 8-bit status/protect register
// assumes spi_sck_i only toggles while spi_cs_n_i is low, that the
// select stays high for at least 3 clk_i periods between frames and
// low for at least 1 clk_i period after the last rising edge
`timescale 1ns/10ps
`include "sfs_consts.svh"
module sfs_front_end
  import sfs_pkg::*;
(
  // system clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // serial link, clocked by the host
  input  wire logic spi_sck_i,
  input  wire logic spi_cs_n_i,
  input  wire logic spi_si_i,
  input  wire logic spi_hold_n_i,
  output logic      spi_so_o,
  output logic      spi_so_oe_n_o,
  // write protect pin
  input  wire logic wp_n_i,
  // status observation
  output sfs_byte_t status_o
);

  // ---------------- link domain, rising edge ----------------
  // the select acts as the asynchronous reset of the link logic: the
  // host clock stops between frames, so nothing else can end a frame
  sfs_phase_e phase_q;
  sfs_phase_e phase_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  sfs_byte_t  shift_q;
  sfs_byte_t  shift_d;
  logic       post_q;
  logic       post_d;
  sfs_cmd_s   cmd_q;
  sfs_cmd_s   cmd_d;
  logic       cmd_load;

  always_comb begin
    phase_d   = phase_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    post_d    = post_q;
    cmd_d     = cmd_q;
    cmd_load  = 1'b0;
    // held transfers see neither clock nor data
    if (spi_hold_n_i) begin // R03
      shift_d   = {shift_q[6:0], spi_si_i}; // R04 R05 R21
      bit_cnt_d = bit_cnt_q + 3'h1;
      case (phase_q)
        SFS_OPCODE: begin
          if (bit_cnt_q == `SFS_LAST_BIT) begin
            phase_d = SFS_IGNORE;
            // R18
            if (shift_d == `SFS_OP_SET_LATCH ||
                shift_d == `SFS_OP_CLEAR_LATCH ||
                shift_d == `SFS_OP_SERIAL_WR ||
                shift_d == `SFS_OP_SECTOR_WR) begin
              cmd_d.opcode = shift_d;
              cmd_d.data   = 8'h00;
              cmd_load     = 1'b1;
              post_d       = 1'b1;
            end else if (shift_d == `SFS_OP_STATUS_RD) begin
              phase_d = SFS_RDSTAT;
            end else if (shift_d == `SFS_OP_STATUS_WR) begin
              phase_d = SFS_WRDATA;
            end
          end
        end
        SFS_WRDATA: begin
          if (bit_cnt_q == `SFS_LAST_BIT) begin
            cmd_d.opcode = `SFS_OP_STATUS_WR;
            cmd_d.data   = shift_d;
            cmd_load     = 1'b1;
            post_d       = 1'b1;
            phase_d      = SFS_IGNORE;
          end
        end
        SFS_RDSTAT: begin
          // input is don't-care while the status byte streams out
          phase_d = SFS_RDSTAT;
        end
        default: begin
          phase_d = SFS_IGNORE;
        end
      endcase
    end
  end

  // a frame cut short leaves post_q low: nothing is executed
  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin // R01 R17
      phase_q   <= SFS_OPCODE; // R02
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
      post_q    <= 1'b0;
    end else begin
      phase_q   <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      post_q    <= post_d;
    end
  end

  // command word holds across the select rise so the system side can
  // still read it after post_q has dropped
  always_ff @(posedge spi_sck_i) begin
    if (cmd_load) begin
      cmd_q <= cmd_d;
    end
  end

  // ---------------- link domain, falling edge ----------------
  logic [2:0] out_cnt_q;
  logic [2:0] out_cnt_d;
  sfs_byte_t  out_buf_q;
  sfs_byte_t  out_buf_d;
  logic       so_q;
  logic       so_d;
  logic       so_oe_n_q;
  logic       so_oe_n_d;
  // clk-domain image, steady while a frame streams it out
  sfs_byte_t  status_img;

  always_comb begin
    out_cnt_d = out_cnt_q;
    out_buf_d = out_buf_q;
    so_d      = so_q;
    so_oe_n_d = 1'b1;
    if (spi_hold_n_i && phase_q == SFS_RDSTAT) begin // R03
      so_oe_n_d = 1'b0; // R06
      out_cnt_d = out_cnt_q + 3'h1;
      // status is reloaded every eighth edge so it repeats endlessly
      if (out_cnt_q == 3'h0) begin // R19
        so_d      = status_img[7]; // R21
        out_buf_d = {status_img[6:0], 1'b0};
      end else begin
        so_d      = out_buf_q[7];
        out_buf_d = {out_buf_q[6:0], 1'b0};
      end
    end
  end

  // in mode 3 the first falling edge comes before the op-code and
  // finds phase_q in SFS_OPCODE, so it leaves the output floating
  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin // R07
    if (spi_cs_n_i) begin // R01
      out_cnt_q <= 3'h0;
      out_buf_q <= 8'h00;
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      out_cnt_q <= out_cnt_d; // R04
      out_buf_q <= out_buf_d;
      so_q      <= so_d;
      so_oe_n_q <= so_oe_n_d;
    end
  end

  assign spi_so_o      = so_q;
  assign spi_so_oe_n_o = so_oe_n_q; // R01 R08

  // ---------------- system domain ----------------
  logic       post_sync;
  logic       wp_n_sync;
  logic       post_seen_q;
  logic       post_seen_d;
  logic       cmd_fire;
  logic [5:0] nv_q;
  logic [5:0] nv_d;
  logic       latch_q;
  logic       latch_d;
  logic       wr_allowed;

  sfs_sync #(
    .W (2)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({post_q, ~wp_n_i}),
    .rst_val_i (2'b01),
    .q_o       ({post_sync, wp_n_sync})
  );

  // the word is stable while post_q is high, so one qualifying flag
  // carries the whole command across
  assign cmd_fire = post_sync & ~post_seen_q;

  // protect pin low with the enable bit set locks the status bits
  assign wr_allowed = latch_q &
                      ~(nv_q[5] & ~wp_n_sync); // R09

  always_comb begin
    post_seen_d = post_sync;
    nv_d        = nv_q;
    latch_d     = latch_q;
    if (cmd_fire) begin
      if (cmd_q.opcode == `SFS_OP_SET_LATCH) begin
        latch_d = 1'b1; // R13
      end else if (cmd_q.opcode == `SFS_OP_CLEAR_LATCH) begin
        latch_d = 1'b0; // R13 R14
      end else if (cmd_q.opcode == `SFS_OP_STATUS_WR) begin
        // data bits 1 and 0 never reach the register
        if (wr_allowed) begin // R09
          nv_d = cmd_q.data[`SFS_NV_HI:`SFS_NV_LO]; // R10 R11 R12 R20
        end
        // latch left set for back-to-back writes
        latch_d = latch_q; // R15
      end else begin
        // serial-number and sector writes also leave the latch set
        latch_d = latch_q; // R15
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_seen_q <= 1'b0;
      nv_q        <= `SFS_NV_RESET;
      latch_q     <= `SFS_LATCH_RESET; // R14
    end else begin
      post_seen_q <= post_seen_d;
      nv_q        <= nv_d;
      latch_q     <= latch_d;
    end
  end

  // commands land within three clocks of the frame's last rising edge, inside
  // the gap between frames, so the link never sees this image move
  always_comb begin
    status_img = {nv_q, latch_q, 1'b0}; // R10 R11 R12 R13 R16
  end

  sfs_byte_t status_out_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_out_q <= 8'h00;
    end else begin
      status_out_q <= status_img;
    end
  end

  assign status_o = status_out_q;

  // R08: slave only; the serial output is floated while deselected

endmodule

// >>> rtl/sfs_pkg.sv
// types shared by the serial status front end
// needs no include; only the front end pulls in sfs_consts.svh
package sfs_pkg;

  typedef enum logic [1:0] {
    SFS_OPCODE,
    SFS_WRDATA,
    SFS_RDSTAT,
    SFS_IGNORE
  } sfs_phase_e;

  typedef logic [7:0] sfs_byte_t;

  typedef struct packed {
    sfs_byte_t opcode;
    sfs_byte_t data;
  } sfs_cmd_s;

endpackage

// >>> rtl/sfs_sync.sv
// two-stage level synchroniser into the system clock domain
// assumes each bit is an independent level; no multi-bit coherence
`timescale 1ns/10ps
module sfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  // reset value comes from a constant tie at the instance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q ^ rst_val_i;

endmodule

// >>> tb/sfs_front_end_chk.sv
// port assertions for the serial status front end
// bound from the bench top; domains clk_i and the link clock
`timescale 1ns/10ps
module sfs_front_end_chk
  import sfs_pkg::*;
(
  // clock and reset
  input wire logic      clk_i,
  input wire logic      rst_i,
  // link
  input wire logic      spi_sck_i,
  input wire logic      spi_cs_n_i,
  input wire logic      spi_si_i,
  input wire logic      spi_hold_n_i,
  input wire logic      spi_so_o,
  input wire logic      spi_so_oe_n_o,
  // protect pin and status
  input wire logic      wp_n_i,
  input wire sfs_byte_t status_o
);
  sequence s_idle;
    spi_cs_n_i [*4];
  endsequence
  sequence s_lock;
    (status_o[7] && !wp_n_i) [*8];
  endsequence
  chk_desel_float:
    assert property (@(posedge clk_i) disable iff (rst_i)
      spi_cs_n_i |-> spi_so_oe_n_o) else $error("driven while deselected");
  chk_zero_bit:
    assert property (@(posedge clk_i) disable iff (rst_i)
      status_o[0] == 1'b0) else $error("status bit 0 set");
  chk_reset_clear:
    assert property (@(posedge clk_i)
      rst_i |=> status_o == 8'h00) else $error("status not cleared");
  chk_so_fall:
    assert property (@(posedge clk_i) disable iff (rst_i)
      (!spi_cs_n_i && !$past(spi_cs_n_i) && $changed(spi_so_o))
      |-> !spi_sck_i) else $error("output moved off falling edge");
  chk_hold_float:
    assert property (@(negedge spi_sck_i) disable iff (spi_cs_n_i)
      !spi_hold_n_i |=> spi_so_oe_n_o) else $error("driven in hold");
  chk_idle_quiet:
    assert property (@(posedge clk_i) disable iff (rst_i)
      s_idle |=> $stable(status_o)) else $error("status moved idle");
  chk_wp_gate:
    assert property (@(posedge clk_i) disable iff (rst_i)
      s_lock |=> $stable(status_o[7:2])) else $error("protected write");
  chk_latch_keep:
    assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(status_o[7:2]) |-> status_o[1] && $past(status_o[1]))
      else $error("write without latch");
endmodule

// >>> tb/sfs_front_end_test.sv
// bench for the serial status front end with host model and scoreboard
// assumes rtl/ design files and tb/ models compile first
`timescale 1ns/10ps
module sfs_front_end_test;
  import sfs_pkg::*;
  logic      clk_i = 0, rst_i = 1, wp_n_i = 1, m;
  logic      sck, cs_n, si, hold_n, so, so_oe_n;
  wire       so_w = !so_oe_n ? so : 1'bz;
  sfs_byte_t status_o, ex, e, d;
  sfs_byte_t exp_q[$];
  sfs_byte_t ops[3] = '{8'hC2, 8'h42, 8'h03};
  int        error_cnt = 0, cmp_count = 0, cyc = 0;
  integer    seed = 32'h75E90F10;
  sfs_front_end dut (.clk_i(clk_i), .rst_i(rst_i), .spi_sck_i(sck),
    .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_hold_n_i(hold_n),
    .spi_so_o(so), .spi_so_oe_n_o(so_oe_n), .wp_n_i(wp_n_i),
    .status_o(status_o));
  sfs_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n), .so_i(so_w));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input sfs_byte_t got, input sfs_byte_t want);
    cmp_count++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic cmd(input sfs_byte_t op, input sfs_byte_t dv,
                     input int n, input int h);
    @(posedge clk_i);
    #1 m = $random(seed);
    host.xfer(m, n, {op, dv, 8'h00}, h);
  endtask
  task automatic rd(input int h);
    exp_q.push_back(ex);
    cmd(8'h05, 8'h00, 24, h);
  endtask
  task automatic wr(input sfs_byte_t dv);
    cmd(8'h01, dv, 16, -1);
    if (ex[1] && (wp_n_i || !ex[7])) ex[7:2] = dv[7:2];
    rd(-1);
  endtask
  task automatic pin(input logic v);
    @(posedge clk_i);
    #1 wp_n_i = v;
  endtask
  initial forever begin
    @(host.done);
    if (host.nbits == 24) begin
      e = exp_q.pop_front();
      cmp(host.rx[15:8], e);
      cmp(host.rx[7:0], e);
      cmp(status_o, e);
    end
  end
  initial begin
    ex = 8'h00;
    repeat (6) @(posedge clk_i);
    #1 rst_i = 0;
    repeat (3) @(posedge clk_i);
    rd(-1);
    wr(8'hFC);
    cmd(8'h06, 8'h00, 8, -1);
    ex[1] = 1;
    rd(-1);
    $display("test latch done");
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      d[7] = 0;
      wr(d);
      rd(k % 3 ? -1 : 20);
      cmd(ops[k % 3], $random(seed), 16, -1);
      rd(-1);
    end
    $display("test writes done");
    wr(8'h80);
    pin(0);
    rd(-1);
    wr(8'h3C);
    pin(1);
    wr(8'h3C);
    $display("test protect done");
    cmd(8'h04, 8'h00, 7, -1);
    rd(-1);
    cmd(8'h04, 8'h00, 8, -1);
    ex[1] = 0;
    rd(-1);
    @(posedge clk_i);
    #1 rst_i = 1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 0;
    ex = 8'h00;
    repeat (3) @(posedge clk_i);
    rd(-1);
    $display("test reset done");
    repeat (20) @(posedge clk_i);
    conclude();
  end
endmodule
bind sfs_front_end sfs_front_end_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .spi_sck_i(spi_sck_i), .spi_cs_n_i(spi_cs_n_i), .spi_si_i(spi_si_i),
  .spi_hold_n_i(spi_hold_n_i), .spi_so_o(spi_so_o),
  .spi_so_oe_n_o(spi_so_oe_n_o), .wp_n_i(wp_n_i), .status_o(status_o));

// >>> tb/sfs_host.sv
// host master model: frames in mode 0 or 3, MSB first
// link clock only steps to the next frame's idle level between frames; bench calls xfer
`timescale 1ns/10ps
module sfs_host (
  // serial link
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i
);
  logic [23:0] rx;
  int          nbits;
  event        done;
  // select starts low and rises once so the link logic is cleared
  // before the first frame; it then idles high
  initial begin
    {sck_o, cs_n_o, si_o, hold_n_o} = 4'h3;
    #2 cs_n_o = 1;
  end
  task automatic xfer(input logic cpol, input int n,
                      input logic [23:0] tx, input int hold_at);
    nbits = n;
    sck_o = cpol;
    #16 cs_n_o = 0;
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) begin
        // one clock runs while held and must be disregarded
        #8 hold_n_o = 0;
        #8 sck_o = 0;
        #16 sck_o = 1;
        #8 hold_n_o = 1;
      end
      #16 sck_o = 0;
      si_o = tx[23-i];
      #16 sck_o = 1;
      rx = {rx[22:0], so_i};
    end
    #16 sck_o = cpol;
    #16 cs_n_o = 1;
    si_o = ~si_o;
    #40 -> done;
  endtask
endmodule
